// *** rtl/pldomc_top.sv ***
// macrocell array with its configuration registers on an axi4-lite slave
//
// Behaviour
// [RULE1] two global bits pick one uniform mode
// [RULE2] two global plus three bits per cell
// [RULE3] sync 0, arch 1 gives registered mode
// [RULE4] sync 1, arch 1 gives complex mode
// [RULE5] sync 1, arch 0 gives simple mode
// [RULE6] polarity bit 0 low, 1 high active
// [RULE7] drive bit 1 totem pole, 0 open drain
// [RULE8] drive defaults to totem pole
// [RULE9] registered mode: direction picks register or io
// [RULE10] registered cells share clock and enable pins
// [RULE11] any cell registered or io, up to eight
// [RULE12] register sums eight terms, io seven
// [RULE13] complex: direction ignored, seven terms plus enable
// [RULE14] complex: outer cells are output only
// [RULE15] complex: dedicated pins ride outer feedback paths
// [RULE16] complex, simple: clock and enable pins are data
// [RULE17] simple: input or always enabled output
// [RULE18] simple: feedback via neighbour, centre cells output
// [RULE19] architecture bits static while running
`timescale 1ns/1ps
module pldomc_top #(
  parameter int NCELL = 8,
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCELL-1:0] pin_i,
  output logic [NCELL-1:0] pin_o,
  output logic [NCELL-1:0] pin_oe,
  input wire logic clk_pin_i,
  input wire logic oe_pin_n_i,
  input wire logic [8*NCELL-1:0] pt_i,
  output logic [NCELL-1:0] fb_o,
  output logic arr_clk_o,
  output logic arr_oe_o
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  generate
    if (NCELL < 4 || NCELL > 8 || (NCELL % 2) != 0 || AW < 5)
    begin : g_bad_param
      $error("pldomc_top: NCELL must be 4, 6 or 8 and AW at least 5");
    end
  endgenerate

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_q;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NCELL-1:0] pin_s1_q;
  logic [NCELL-1:0] pin_s2_q;
  logic clk_s1_q;
  logic clk_s2_q;
  logic clk_prev_q;
  logic oe_s1_q;
  logic oe_s2_q;
  logic arr_clk_d;
  logic arr_oe_d;
  logic clk_rise;
  logic run_q;
  logic [1:0] act_glb_q;
  logic [23:0] act_mc_q;
  pldomc_pkg::pldomc_mode_t mode;

  assign mode = pldomc_pkg::pldomc_mode_t'({act_glb_q[pldomc_pkg::GLB_SYNC_BIT],
    act_glb_q[pldomc_pkg::GLB_ARCH_BIT]}); // RULE1 RULE3 RULE4 RULE5
  assign clk_rise = clk_s2_q & ~clk_prev_q;

  // dedicated pins reach the array only outside registered mode
  always_comb
  begin
    arr_clk_d = 1'b0;
    arr_oe_d = 1'b0;
    if (run_q && (mode == pldomc_pkg::MODE_CPLX ||
        mode == pldomc_pkg::MODE_SIMPLE)) // RULE10 RULE16
    begin
      arr_clk_d = clk_s2_q;
      arr_oe_d = oe_s2_q;
    end
  end

  // two flops per pin, third flop for clock pin edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_prev_q <= 1'b0;
      oe_s1_q <= 1'b1;
      oe_s2_q <= 1'b1;
      arr_clk_o <= 1'b0;
      arr_oe_o <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      clk_s1_q <= clk_pin_i;
      clk_s2_q <= clk_s1_q;
      clk_prev_q <= clk_s2_q;
      oe_s1_q <= oe_pin_n_i;
      oe_s2_q <= oe_s1_q;
      arr_clk_o <= arr_clk_d;
      arr_oe_o <= arr_oe_d;
    end
  end

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [AW-1:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic awready_d, wready_d, bvalid_d;
  logic [1:0] bresp_d;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_mask;

  // address and data taken in either order, response after both
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    wr_en = 1'b0;
    wr_addr = 8'(aw_addr_q);
    wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
      {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (aw_have_q && w_have_q && !s_axi_bvalid)
    begin
      wr_en = 1'b1;
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      case (wr_addr)
        pldomc_pkg::ADDR_CTRL,
        pldomc_pkg::ADDR_GLOBAL,
        pldomc_pkg::ADDR_MCELL: bresp_d = pldomc_pkg::RESP_OKAY;
        default: bresp_d = pldomc_pkg::RESP_SLVERR;
      endcase
    end
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d = ~w_have_d & ~bvalid_d;
  end

  // write channel flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pldomc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic run_d;
  logic [1:0] glb_q, glb_d, act_glb_d;
  logic [23:0] mc_q, mc_d, act_mc_d;
  logic [31:0] mc_wr;

  // shadow copies written by software, active copy frozen while running
  always_comb
  begin
    run_d = run_q;
    glb_d = glb_q;
    mc_d = mc_q;
    mc_wr = ({8'h00, mc_q} & ~wr_mask) | (w_data_q & wr_mask);
    if (wr_en && wr_addr == pldomc_pkg::ADDR_CTRL && w_strb_q[0])
    begin
      run_d = w_data_q[pldomc_pkg::CTRL_RUN_BIT];
    end
    if (wr_en && wr_addr == pldomc_pkg::ADDR_GLOBAL && w_strb_q[0])
    begin
      glb_d = w_data_q[1:0]; // RULE1 RULE2
    end
    if (wr_en && wr_addr == pldomc_pkg::ADDR_MCELL)
    begin
      mc_d = mc_wr[23:0]; // RULE2
    end
    act_glb_d = run_q ? act_glb_q : glb_q; // RULE19
    act_mc_d = run_q ? act_mc_q : mc_q; // RULE19
  end

  // configuration flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= pldomc_pkg::RST_RUN;
      glb_q <= pldomc_pkg::RST_GLOBAL;
      mc_q <= {pldomc_pkg::RST_DRV, pldomc_pkg::RST_DIR,
        pldomc_pkg::RST_POL}; // RULE8
      act_glb_q <= pldomc_pkg::RST_GLOBAL;
      act_mc_q <= {pldomc_pkg::RST_DRV, pldomc_pkg::RST_DIR,
        pldomc_pkg::RST_POL};
    end
    else if (ce)
    begin
      run_q <= run_d;
      glb_q <= glb_d;
      mc_q <= mc_d;
      act_glb_q <= act_glb_d;
      act_mc_q <= act_mc_d;
    end
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  logic arready_d, rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0] rresp_d;
  logic [7:0] rd_addr;

  // one read at a time, data registered with the valid
  always_comb
  begin
    rd_addr = 8'(s_axi_araddr);
    rvalid_d = s_axi_rvalid;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = pldomc_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      case (rd_addr)
        pldomc_pkg::ADDR_CTRL:
          rdata_d[pldomc_pkg::CTRL_RUN_BIT] = run_q;
        pldomc_pkg::ADDR_GLOBAL:
          rdata_d[1:0] = glb_q;
        pldomc_pkg::ADDR_MCELL:
          rdata_d[23:0] = mc_q;
        pldomc_pkg::ADDR_STATUS:
        begin
          rdata_d[pldomc_pkg::ST_RUN_BIT] = run_q;
          rdata_d[pldomc_pkg::ST_MODE_LSB +: 2] = mode;
          rdata_d[pldomc_pkg::ST_BAD_BIT] = (mode == pldomc_pkg::MODE_BAD);
        end
        pldomc_pkg::ADDR_PINS:
        begin
          rdata_d[pldomc_pkg::PIN_OUT_LSB +: NCELL] = pin_o;
          rdata_d[pldomc_pkg::PIN_OE_LSB +: NCELL] = pin_oe;
          rdata_d[pldomc_pkg::PIN_FB_LSB +: NCELL] = fb_o;
        end
        default:
          rresp_d = pldomc_pkg::RESP_SLVERR;
      endcase
    end
    arready_d = ~rvalid_d;
  end

  // read channel flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pldomc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

  // ----------------------------------------
  // macrocell array
  // ----------------------------------------
  logic cell_en;

  assign cell_en = run_q & (mode != pldomc_pkg::MODE_BAD); // RULE1

  // one cell per output, outer cells carry the dedicated pins
  generate
    for (genvar i = 0; i < NCELL; i++)
    begin : g_cell
      localparam bit IS_OUTER = (i == 0) || (i == NCELL - 1);
      localparam bit IS_CENTER = (i == NCELL / 2 - 1) || (i == NCELL / 2);
      localparam int NBR = (i < NCELL / 2) ? i + 1 : i - 1;
      logic alt;
      assign alt = (i == 0) ? oe_s2_q : clk_s2_q; // RULE15
      pldomc_cell #(
        .OUTER(IS_OUTER),
        .CENTER(IS_CENTER)
      ) u_cell (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .ce(ce),
        .en(cell_en),
        .mode(mode),
        .pol(act_mc_q[pldomc_pkg::MC_POL_LSB + i]), // RULE6
        .dir(act_mc_q[pldomc_pkg::MC_DIR_LSB + i]), // RULE9 RULE13
        .drive(act_mc_q[pldomc_pkg::MC_DRV_LSB + i]), // RULE7
        .pt(pt_i[8*i +: 8]),
        .pin_s(pin_s2_q[i]),
        .nbr_s(pin_s2_q[NBR]), // RULE18
        .alt_s(alt),
        .clk_rise(clk_rise), // RULE10
        .oe_n_s(oe_s2_q),
        .pin_o_q(pin_o[i]),
        .pin_oe_q(pin_oe[i]),
        .fb_q(fb_o[i]),
        .reg_q()
      );
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_status_read;
    ce && s_axi_arvalid && s_axi_arready &&
      s_axi_araddr == AW'(pldomc_pkg::ADDR_STATUS);
  endsequence

  a_cfg_frozen: assert property (run_q && $past(run_q) |->
    act_mc_q == $past(act_mc_q) && act_glb_q == $past(act_glb_q)) // RULE19
    else $error("architecture bits changed while running");
  a_status_mode: assert property (s_status_read |=>
    s_axi_rdata[2:1] == {$past(act_glb_q[0]), $past(act_glb_q[1])}) // RULE3
    else $error("status mode field disagrees with global bits");
  a_reg_pins: assert property (ce && run_q && mode == pldomc_pkg::MODE_REG
    |=> !arr_clk_o && !arr_oe_o) // RULE10
    else $error("clock or enable pin leaked into array");
  a_data_pins: assert property (ce && run_q && mode == pldomc_pkg::MODE_SIMPLE
    |=> arr_clk_o == $past(clk_s2_q) && arr_oe_o == $past(oe_s2_q)) // RULE16
    else $error("dedicated pins not passed to array");
  a_bad_quiet: assert property (ce && mode == pldomc_pkg::MODE_BAD
    |=> pin_oe == '0) // RULE1
    else $error("outputs driven in undefined mode");

endmodule // pldomc_top

// *** rtl/pldomc_pkg.sv ***
// shared constants and types of the output macrocell configuration block
package pldomc_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL = 8'h04;
  localparam logic [7:0] ADDR_MCELL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_PINS = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned GLB_SYNC_BIT = 0;
  localparam int unsigned GLB_ARCH_BIT = 1;
  localparam int unsigned MC_POL_LSB = 0;
  localparam int unsigned MC_DIR_LSB = 8;
  localparam int unsigned MC_DRV_LSB = 16;
  localparam int unsigned ST_RUN_BIT = 0;
  localparam int unsigned ST_MODE_LSB = 1;
  localparam int unsigned ST_BAD_BIT = 3;
  localparam int unsigned PIN_OUT_LSB = 0;
  localparam int unsigned PIN_OE_LSB = 8;
  localparam int unsigned PIN_FB_LSB = 16;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_RUN = 1'b0;
  localparam logic [1:0] RST_GLOBAL = 2'h1;
  localparam logic [7:0] RST_POL = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [7:0] RST_DRV = 8'hff;

  // ----------------------------------------
  // bus answers and modes
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // code is {sync_mode_select, global_arch_select}
  typedef enum logic [1:0] {
    MODE_BAD = 2'b00,
    MODE_REG = 2'b01,
    MODE_SIMPLE = 2'b10,
    MODE_CPLX = 2'b11
  } pldomc_mode_t;

endpackage

// *** rtl/pldomc_cell.sv ***
// one output macrocell: mode, polarity, drive and feedback selection
`timescale 1ns/1ps
module pldomc_cell #(
  parameter bit OUTER = 1'b0,
  parameter bit CENTER = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic en,
  input wire pldomc_pkg::pldomc_mode_t mode,
  input wire logic pol,
  input wire logic dir,
  input wire logic drive,
  input wire logic [7:0] pt,
  input wire logic pin_s,
  input wire logic nbr_s,
  input wire logic alt_s,
  input wire logic clk_rise,
  input wire logic oe_n_s,
  output logic pin_o_q,
  output logic pin_oe_q,
  output logic fb_q,
  output logic reg_q
);

  logic sum8;
  logic sum7;
  logic dir_eff;
  logic val;
  logic oe;
  logic reg_d;
  logic fb_d;
  logic pin_o_d;
  logic pin_oe_d;
  logic go;

  // ----------------------------------------
  // macrocell next state
  // ----------------------------------------
  // sums, mode selection, polarity and drive
  always_comb
  begin
    sum8 = |pt;
    sum7 = |pt[6:0];
    dir_eff = CENTER ? 1'b0 : dir; // RULE18
    go = en & ce;
    reg_d = reg_q;
    val = 1'b0;
    oe = 1'b0;
    fb_d = 1'b0;
    case (mode)
      pldomc_pkg::MODE_REG:
      begin
        if (!dir) // RULE9 RULE11
        begin
          if (clk_rise)
          begin
            reg_d = sum8; // RULE12
          end
          val = reg_q ~^ pol; // RULE6
          oe = ~oe_n_s; // RULE10
          fb_d = reg_q;
        end
        else
        begin
          val = sum7 ~^ pol; // RULE12
          oe = pt[7];
          fb_d = pin_s;
        end
      end
      pldomc_pkg::MODE_CPLX:
      begin
        val = sum7 ~^ pol; // RULE13
        oe = pt[7]; // RULE13
        fb_d = OUTER ? alt_s : pin_s; // RULE14 RULE15
      end
      pldomc_pkg::MODE_SIMPLE:
      begin
        if (!dir_eff)
        begin
          val = sum8 ~^ pol; // RULE17
          oe = 1'b1; // RULE17
        end
        fb_d = CENTER ? 1'b0 : nbr_s; // RULE18
      end
      default:
      begin
        val = 1'b0;
      end
    endcase
    if (!en)
    begin
      oe = 1'b0;
      fb_d = 1'b0;
      reg_d = reg_q;
    end
    pin_o_d = drive ? val : 1'b0; // RULE7
    pin_oe_d = drive ? oe : (oe & ~val); // RULE7 RULE8
  end

  // macrocell flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_q <= 1'b0;
      fb_q <= 1'b0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end
    else if (ce)
    begin
      reg_q <= reg_d;
      fb_q <= fb_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_reg_edge;
    go && mode == pldomc_pkg::MODE_REG && !dir && clk_rise;
  endsequence

  a_open_drain: assert property (pin_oe_q && !$past(drive) |-> !pin_o_q) // RULE7
    else $error("open-drain cell drove high");
  a_reg_capture: assert property (s_reg_edge |=> reg_q == $past(sum8)) // RULE9
    else $error("registered cell missed clock edge");
  a_reg_hold: assert property (go && mode == pldomc_pkg::MODE_REG && !clk_rise
    |=> reg_q == $past(reg_q)) // RULE10
    else $error("register changed without clock pin edge");
  a_simple_on: assert property (go && mode == pldomc_pkg::MODE_SIMPLE && !dir_eff
    && drive |=> pin_oe_q && pin_o_q == ($past(sum8) ~^ $past(pol))) // RULE17
    else $error("simple output not enabled or wrong level");
  a_cmplx_oe: assert property (go && mode == pldomc_pkg::MODE_CPLX && drive
    |=> pin_oe_q == $past(pt[7])) // RULE13
    else $error("complex output enable not from product term");
  a_pol_level: assert property (go && mode == pldomc_pkg::MODE_CPLX && drive
    && pt[7] |=> pin_o_q == ($past(sum7) ~^ $past(pol))) // RULE6
    else $error("output polarity wrong");

  generate
    if (OUTER)
    begin : g_outer_chk
      a_outer_fb: assert property (go && mode == pldomc_pkg::MODE_CPLX
        |=> fb_q == $past(alt_s)) // RULE15
        else $error("outer feedback not carrying dedicated pin");
    end
    if (CENTER)
    begin : g_center_chk
      a_center_out: assert property (go && mode == pldomc_pkg::MODE_SIMPLE
        |=> !fb_q) // RULE18
        else $error("centre cell has feedback in simple mode");
    end
  endgenerate

endmodule // pldomc_cell

// *** bench/pldomc_board.sv ***
// board-side model of the macrocell pins
`timescale 1ns/1ps
module pldomc_board (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  // design drive first, then board drive, else the pull-up level
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'h1);
    end
  end
endmodule // pldomc_board

// *** bench/testbench.sv ***
// self-checking bench of the macrocell configuration block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [1:0] glb;
    logic [7:0] pol;
    logic [7:0] dir;
    logic [7:0] drv;
    logic [7:0] pt;
    logic [3:0] st;
    logic [7:0] oe;
    logic [7:0] po;
  } pldomc_row_t;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awv = 1'h0;
  logic wv = 1'h0;
  logic arv = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic awr, wr, bv, arr, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, got;
  logic [7:0] pin_i, pin_o, pin_oe, fb;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] pt = 8'h00;
  logic clk_pin = 1'h0;
  logic oe_n = 1'h0;
  logic arr_clk, arr_oe;
  int fail_count = 0;
  int checked = 0;
  pldomc_row_t rows [10];

  pldomc_top u_dut (
    .core_clk(core_clk), .nrst(nrst), .ce(1'h1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(1'h1), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(1'h1), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .clk_pin_i(clk_pin),
    .oe_pin_n_i(oe_n), .pt_i({8{pt}}), .fb_o(fb),
    .arr_clk_o(arr_clk), .arr_oe_o(arr_oe)
  );

  pldomc_board u_board (
    .pin_o(pin_o), .pin_oe(pin_oe), .ext_en(ext_en),
    .ext_val(ext_val), .pin_i(pin_i)
  );

  // clock of 50 ns period
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // a handshake that never came ends the run
  task automatic tmo(input int n);
    if (n >= 100)
    begin
      fail_count++;
      end_of_test();
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
    end while (!bv && n < 100);
    tmo(n);
    chk("bresp", bresp, er);
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'h1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arr) arv <= 1'h0;
    end while (!rv && n < 100);
    tmo(n);
    got = rdata;
    chk("rresp", rresp, er);
  endtask

  // stop, load mode and cell bits, run; pin paths need 3 edges
  task automatic cfg(input logic [1:0] g, input logic [23:0] m);
    axw(pldomc_pkg::ADDR_CTRL, 32'h0, pldomc_pkg::RESP_OKAY);
    axw(pldomc_pkg::ADDR_GLOBAL, {30'h0, g}, pldomc_pkg::RESP_OKAY);
    axw(pldomc_pkg::ADDR_MCELL, {8'h00, m}, pldomc_pkg::RESP_OKAY);
    axw(pldomc_pkg::ADDR_CTRL, 32'h1, pldomc_pkg::RESP_OKAY);
    repeat (5) @(posedge core_clk);
  endtask

  // enables, and pin values where enabled
  task automatic pins(input logic [7:0] eo, input logic [7:0] ep);
    axr(pldomc_pkg::ADDR_PINS, pldomc_pkg::RESP_OKAY);
    chk("pin_oe", {24'h0, got[15:8]}, {24'h0, eo});
    chk("pin_o", {24'h0, got[7:0] & got[15:8]}, {24'h0, ep});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    // mode, pol, dir, drive, terms -> status, enables, pins
    rows = '{
      {2'h1, 8'hff, 8'h00, 8'hff, 8'h01, 4'h5, 8'hff, 8'hff},
      {2'h1, 8'h00, 8'h00, 8'hff, 8'h01, 4'h5, 8'hff, 8'h00},
      {2'h1, 8'hff, 8'hff, 8'hff, 8'h01, 4'h5, 8'h18, 8'h18},
      {2'h1, 8'h00, 8'h00, 8'h00, 8'h01, 4'h5, 8'hff, 8'h00},
      {2'h1, 8'hff, 8'h00, 8'h00, 8'h01, 4'h5, 8'h00, 8'h00},
      {2'h3, 8'hff, 8'h00, 8'hff, 8'h81, 4'h7, 8'hff, 8'hff},
      {2'h3, 8'hff, 8'hff, 8'hff, 8'h80, 4'h7, 8'hff, 8'h00},
      {2'h3, 8'hff, 8'h00, 8'hff, 8'h01, 4'h7, 8'h00, 8'h00},
      {2'h2, 8'h00, 8'hff, 8'hff, 8'h81, 4'h3, 8'hff, 8'h00},
      {2'h0, 8'hff, 8'h00, 8'hff, 8'h81, 4'h9, 8'h00, 8'h00}};
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    repeat (4) @(posedge core_clk);
    // reset values and refused addresses
    axr(pldomc_pkg::ADDR_CTRL, pldomc_pkg::RESP_OKAY);
    chk("ctrl", got, 32'h0);
    axr(pldomc_pkg::ADDR_GLOBAL, pldomc_pkg::RESP_OKAY);
    chk("global", got, 32'h1);
    axr(pldomc_pkg::ADDR_MCELL, pldomc_pkg::RESP_OKAY);
    chk("mcell", got, 32'h00ff0000);
    axr(pldomc_pkg::ADDR_STATUS, pldomc_pkg::RESP_OKAY);
    chk("status", got, 32'h4);
    axr(8'h14, pldomc_pkg::RESP_SLVERR);
    chk("unmapped", got, 32'h0);
    axw(8'h14, 32'h1, pldomc_pkg::RESP_SLVERR);
    axw(pldomc_pkg::ADDR_STATUS, 32'h1, pldomc_pkg::RESP_SLVERR);
    // ordinary configurations
    foreach (rows[i])
    begin
      pt <= rows[i].pt;
      cfg(rows[i].glb, {rows[i].drv, rows[i].dir, rows[i].pol});
      axr(pldomc_pkg::ADDR_STATUS, pldomc_pkg::RESP_OKAY);
      chk("mode", got, {28'h0, rows[i].st});
      pins(rows[i].oe, rows[i].po);
    end
    // registered cells on the shared clock and enable pins
    pt <= 8'h80;
    cfg(2'h2, 24'hfff0ff);
    pins(8'hff, 8'h00);
    clk_pin <= 1'h1;
    repeat (5) @(posedge core_clk);
    chk("arr_clk", {31'h0, arr_clk}, 32'h0);
    pins(8'hff, 8'h0f);
    oe_n <= 1'h1;
    repeat (5) @(posedge core_clk);
    pins(8'hf0, 8'h00);
    axw(pldomc_pkg::ADDR_GLOBAL, 32'h3, pldomc_pkg::RESP_OKAY);
    axr(pldomc_pkg::ADDR_STATUS, pldomc_pkg::RESP_OKAY);
    chk("frozen", got, 32'h3);
    // complex: outer feedbacks carry the clock and enable pins, not their own pins
    pt <= 8'h01;
    ext_en <= 8'h81;
    cfg(2'h3, 24'hff00ff);
    chk("clk_fb", {30'h0, fb[7], arr_clk}, 32'h3);
    chk("oe_fb", {30'h0, fb[0], arr_oe}, 32'h3);
    // simple: feedback through neighbour pins, centre cells output
    clk_pin <= 1'h0;
    ext_en <= 8'he7;
    ext_val <= 8'h5a;
    cfg(2'h1, 24'hffffff);
    chk("fb", {24'h0, fb}, 32'ha5);
    end_of_test();
  end
endmodule // testbench
